// >>> shader_tex_consts.svh
/*
  Named constants of the shader and texture parameter bank: parameter types,
  sub-addresses, field positions and instruction ranges.
  Assumes it is included by its bare name, once or more.
*/
`ifndef SHADER_TEX_CONSTS_SVH
`define SHADER_TEX_CONSTS_SVH

`define PT_SHADER       8'h01
`define PT_TEXTURE      8'h02
`define SA_PS10         8'h99
`define SA_PS11         8'h9A
`define SA_INSPECT      8'hAA
`define SA_FACE_LAST    8'h04
`define SA_TEX_LAST     8'h51
`define SUBTYPE_LAST    8'h0F
`define SUBADDR_MSB     31
`define SUBADDR_LSB     24
`define PAYLOAD_MSB     23
`define PS11_SW_MSB     7
`define DSTCHK_LSB      8
`define DSTCHK_MSB      23
`define INSPECT_MSB     13
`define ALU_FIRST       7'h5F
`define ALU_LAST        7'h7F
`define BASE_LSB_ZEROS  8'h00
`define PAYLOAD_ZERO    24'h000000
`define FLAG_ZERO       14'h0000
`define SW_ZERO         33'h000000000
`define CHK_ZERO        16'h0000
`define ADDR_ZERO       32'h00000000
`define FACE_LAST       3'h4
`define FACE_ZERO       3'h0
`define FACE_IDX_MSB    2
`define STAGE_IDX_MSB   3
`define N_STAGES        16
`define N_FACES         5
`define SW_PS10_MSB     23
`define SW_PS11_LSB     25
`define SW_MSB          32
`define SW_OFFSET_MSB   5
`define NO_SWITCH       1'b0

`endif

// >>> shader_tex_pkg.sv
/*
  Types shared by the shader and texture parameter bank.
  Assumes nothing; every width is a literal matching the constants header.
*/
package shader_tex_pkg;
  typedef logic [23:0] payload_t;
  typedef logic [7:0]  sub_addr_t;
  typedef logic [3:0]  stage_t;
  typedef logic [2:0]  face_t;
  typedef logic [32:0] switch_vec_t;
  typedef logic [15:0] dst_check_t;
endpackage

// >>> shader_texture_param_bank.sv
/*
  Write-only parameter bank: pixel shader switch bits and destination check
  bits, software inspection flag, and per-stage face level-0 base addresses.
  Assumes one engine clock, parameter words synchronous to it, and the
  shader core presenting lookups from its own pipeline.
*/
`timescale 1ns/1ps
`include "shader_tex_consts.svh"

// Overview of operation
// - A set switch bit moves execution to a texture-unit instruction after its ALU instruction, a clear bit runs the next ALU instruction.
// - Shader setting 10 bit 0 covers the switch after ALU instruction 95 and each higher bit the next instruction.
// - Shader setting 11 bits 0 to 7 cover the switch after ALU instructions 120 to 127.
// - Shader setting 11 bits 8 to 23 hold the destination check bits of temporaries 0 to 15.
// - A set check bit makes the shader test that register's valid bit on its first use as ALU destination, a clear bit skips the test.
// - With checking on, a partial ALU write waits until the register's valid bit from a texture load is set.
// - The inspection register at sub-address AAh holds a flag number in bits 13:0, bits 23:14 reserved.
// - Type 02h words go to texture stage 0 to F by subtype 00h to 0Fh.
// - The sub-address is taken from word bits 31:24, texture sub-addresses spanning 00h to 51h.
// - Sub-addresses 00h to 04h hold face 0 to 4 level-0 base addresses as address bits 31 to 8.
module shader_texture_param_bank (
  input  wire logic                       clk_i,          // engine clock
  input  wire logic                       rst_n_i,        // async reset, active low
  input  wire logic                       param_valid_i,  // parameter word present
  input  wire logic [7:0]                 param_type_i,   // param_type_field
  input  wire logic [7:0]                 param_subtype_i,// param_subtype_field
  input  wire logic [31:0]                param_word_i,   // sub-address and payload
  input  wire logic                       alu_query_i,    // ask switch after alu_index_i
  input  wire logic [6:0]                 alu_index_i,    // ALU instruction number
  output logic                            switch_valid_o, // switch answer present
  output logic                            switch_known_o, // index held by this bank
  output logic                            switch_tex_o,   // go to texture_op_unit
  input  wire logic [3:0]                 dst_reg_i,      // ALU destination temporary
  input  wire logic                       dst_first_use_i,// first use as ALU destination
  input  wire logic                       dst_partial_i,  // write covers part of register
  input  wire logic                       dst_reg_valid_i,// valid bit from texture load
  output logic                            alu_stall_o,    // hold the ALU instruction
  input  wire shader_tex_pkg::stage_t     tex_stage_i,    // texture stage to look up
  input  wire shader_tex_pkg::face_t      tex_face_i,     // face to look up
  output logic [31:0]                     face_base_o,    // byte address of level 0
  output logic                            face_known_o,   // face held by this bank
  output logic [13:0]                     inspect_flag_o  // software inspection flag
);

  // stored settings; each next value is decoded below
  shader_tex_pkg::switch_vec_t switch_q;
  shader_tex_pkg::switch_vec_t switch_d;
  shader_tex_pkg::dst_check_t  dst_check_q;
  shader_tex_pkg::dst_check_t  dst_check_d;
  logic [13:0]                 inspect_q;
  logic [13:0]                 inspect_d;

  // registered lookup answers
  logic                        switch_valid_q;
  logic                        switch_valid_d;
  logic                        switch_known_q;
  logic                        switch_known_d;
  logic                        switch_tex_q;
  logic                        switch_tex_d;
  logic [31:0]                 face_addr_q;
  logic [31:0]                 face_addr_d;
  logic                        face_known_q;
  logic                        face_known_d;

  // decode of the incoming word
  shader_tex_pkg::sub_addr_t   sub_addr;
  shader_tex_pkg::payload_t    payload;
  wire                         is_shader;
  wire                         is_tex;
  wire                         wr_ps10;
  wire                         wr_ps11;
  wire                         wr_inspect;
  wire                         wr_face;
  wire [2:0]                   wr_face_idx;
  wire [3:0]                   wr_stage;

  assign sub_addr    = param_word_i[`SUBADDR_MSB:`SUBADDR_LSB];
  assign payload     = param_word_i[`PAYLOAD_MSB:0];
  assign is_shader   = param_valid_i && (param_type_i == `PT_SHADER);
  assign is_tex      = param_valid_i && (param_type_i == `PT_TEXTURE)
                       && (param_subtype_i <= `SUBTYPE_LAST);
  assign wr_ps10     = is_shader && (sub_addr == `SA_PS10);
  assign wr_ps11     = is_shader && (sub_addr == `SA_PS11);
  assign wr_inspect  = is_shader && (sub_addr == `SA_INSPECT);
  assign wr_face     = is_tex && (sub_addr <= `SA_FACE_LAST);
  assign wr_face_idx = sub_addr[`FACE_IDX_MSB:0];
  assign wr_stage    = param_subtype_i[`STAGE_IDX_MSB:0];

  // payload fields of the shader settings
  wire [23:0]                  ps10_sw;
  wire [7:0]                   ps11_sw;
  wire [15:0]                  ps11_chk;
  wire [13:0]                  inspect_field;
  wire [23:0]                  ps10_sw_d;
  wire [7:0]                   ps11_sw_d;

  assign ps10_sw       = payload;
  assign ps11_sw       = payload[`PS11_SW_MSB:0];
  assign ps11_chk      = payload[`DSTCHK_MSB:`DSTCHK_LSB];
  assign inspect_field = payload[`INSPECT_MSB:0];

  // bits 0..23 are instructions 95..118, bits 25..32 are 120..127
  // instruction 119 has no switch bit, so it always runs the next ALU one
  assign ps10_sw_d   = wr_ps10 ? ps10_sw : switch_q[`SW_PS10_MSB:0];
  assign ps11_sw_d   = wr_ps11 ? ps11_sw : switch_q[`SW_MSB:`SW_PS11_LSB];
  assign switch_d    = {ps11_sw_d, `NO_SWITCH, ps10_sw_d};
  assign dst_check_d = wr_ps11 ? ps11_chk : dst_check_q;
  assign inspect_d   = wr_inspect ? inspect_field : inspect_q;

  // switch lookup
  wire                         alu_in_range;
  wire [6:0]                   alu_offset;
  wire                         switch_bit;

  assign alu_in_range   = (alu_index_i >= `ALU_FIRST) && (alu_index_i <= `ALU_LAST);
  assign alu_offset     = alu_index_i - `ALU_FIRST;
  assign switch_bit     = switch_q[alu_offset[`SW_OFFSET_MSB:0]];
  assign switch_valid_d = alu_query_i;
  assign switch_known_d = alu_query_i && alu_in_range;
  assign switch_tex_d   = switch_known_d && switch_bit;

  // face lookup; the read index is clamped so no store is read out of range
  wire                         face_in_range;
  wire [2:0]                   face_rd_idx;
  wire [23:0]                  stage_face_word [`N_STAGES];

  assign face_in_range = (tex_face_i <= `FACE_LAST);
  assign face_rd_idx   = face_in_range ? tex_face_i : `FACE_ZERO;
  assign face_known_d  = face_in_range;
  assign face_addr_d   = face_in_range
                         ? {stage_face_word[tex_stage_i], `BASE_LSB_ZEROS}
                         : `ADDR_ZERO;

  // face base store, one bank of level-0 words per texture stage
  for (genvar s = 0; s < `N_STAGES; s++) begin : g_stage
    shader_tex_pkg::payload_t  face_q [`N_FACES];
    wire                       stage_wr;

    assign stage_wr           = wr_face && (wr_stage == 4'(s));
    assign stage_face_word[s] = face_q[face_rd_idx];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        for (int f = 0; f < `N_FACES; f++) begin
          face_q[f] <= `PAYLOAD_ZERO;
        end
      end else if (stage_wr) begin
        face_q[wr_face_idx] <= payload;
      end
    end
  end

  // switch bits of both settings
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      switch_q <= `SW_ZERO;
    end else begin
      switch_q <= switch_d;
    end
  end

  // destination check bits
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dst_check_q <= `CHK_ZERO;
    end else begin
      dst_check_q <= dst_check_d;
    end
  end

  // inspection flag, reserved payload bits dropped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inspect_q <= `FLAG_ZERO;
    end else begin
      inspect_q <= inspect_d;
    end
  end

  // switch answer, one cycle after the query
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      switch_valid_q <= 1'b0;
      switch_known_q <= 1'b0;
      switch_tex_q   <= 1'b0;
    end else begin
      switch_valid_q <= switch_valid_d;
      switch_known_q <= switch_known_d;
      switch_tex_q   <= switch_tex_d;
    end
  end

  // face address answer, one cycle after the lookup inputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      face_addr_q  <= `ADDR_ZERO;
      face_known_q <= 1'b0;
    end else begin
      face_addr_q  <= face_addr_d;
      face_known_q <= face_known_d;
    end
  end

  // hold a partial write until the texture load has landed
  wire                         dst_check_bit;
  wire                         dst_waits;

  assign dst_check_bit = dst_check_q[dst_reg_i];
  assign dst_waits     = dst_first_use_i && dst_partial_i && !dst_reg_valid_i;
  assign alu_stall_o   = dst_check_bit && dst_waits;

  // registered outputs
  assign switch_valid_o = switch_valid_q;
  assign switch_known_o = switch_known_q;
  assign switch_tex_o   = switch_tex_q;
  assign face_base_o    = face_addr_q;
  assign face_known_o   = face_known_q;
  assign inspect_flag_o = inspect_q;

endmodule

// >>> shader_texture_param_bank_assertions.sv
/*
  Checker of the bank's lookup, stall and flag ports.
  Assumes a bind to the bank and its single engine clock.
*/
`timescale 1ns/1ps
module shader_texture_param_bank_assertions (
  input wire logic                   clk_i,           // engine clock
  input wire logic                   rst_n_i,         // async reset, active low
  input wire logic                   param_valid_i,   // word present
  input wire logic                   alu_query_i,     // switch query
  input wire logic                   switch_valid_o,  // switch answer present
  input wire logic                   switch_known_o,  // index held by the bank
  input wire logic                   switch_tex_o,    // switch to texture unit
  input wire logic                   dst_first_use_i, // first destination use
  input wire logic                   dst_partial_i,   // partial write
  input wire logic                   dst_reg_valid_i, // texture load landed
  input wire logic                   alu_stall_o,     // ALU hold
  input wire logic                   face_known_o,    // face held by the bank
  input wire logic [6:0]             alu_index_i,     // ALU instruction number
  input wire logic [31:0]            face_base_o,     // level-0 byte address
  input wire logic [13:0]            inspect_flag_o,  // inspection flag
  input wire shader_tex_pkg::face_t  tex_face_i       // face looked up
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_in_range; alu_query_i && alu_index_i >= 7'h5F; endsequence
  sequence s_out_range; alu_query_i && alu_index_i < 7'h5F; endsequence
  property p_answer; alu_query_i |=> switch_valid_o; endproperty
  a_answer: assert property (p_answer) else $error("query not answered");
  property p_quiet; !alu_query_i |=> !switch_valid_o; endproperty
  a_quiet: assert property (p_quiet) else $error("answer without query");
  property p_known; s_in_range |=> switch_known_o; endproperty
  a_known: assert property (p_known) else $error("held index not known");
  property p_outside; s_out_range |=> !switch_known_o && !switch_tex_o; endproperty
  a_outside: assert property (p_outside) else $error("low index answered");
  property p_stall; alu_stall_o |-> dst_first_use_i && dst_partial_i && !dst_reg_valid_i;
  endproperty
  a_stall: assert property (p_stall) else $error("stall without cause");
  property p_face; 1'b1 |=> face_known_o == ($past(tex_face_i) <= 3'h4); endproperty
  a_face: assert property (p_face) else $error("face known wrong");
  property p_units; face_base_o[7:0] == 8'h00; endproperty
  a_units: assert property (p_units) else $error("base not 256 byte aligned");
  property p_flag; !param_valid_i |=> $stable(inspect_flag_o); endproperty
  a_flag: assert property (p_flag) else $error("flag changed without word");
endmodule
bind shader_texture_param_bank shader_texture_param_bank_assertions i_chk (.clk_i, .rst_n_i,
  .param_valid_i, .alu_query_i, .switch_valid_o, .switch_known_o, .switch_tex_o,
  .dst_first_use_i, .dst_partial_i, .dst_reg_valid_i, .alu_stall_o, .face_known_o,
  .alu_index_i, .face_base_o, .inspect_flag_o, .tex_face_i);

// >>> param_word_source.sv
/*
  Command stream model handing typed parameter words to the bank.
  Assumes the bank takes a word at each rising edge with valid high.
*/
`timescale 1ns/1ps
module param_word_source (
  input  wire logic   clk_i,     // engine clock
  output logic        valid_o,   // word present
  output logic [7:0]  type_o,    // param_type_field
  output logic [7:0]  subtype_o, // param_subtype_field
  output logic [31:0] word_o     // sub-address and payload
);
  initial {valid_o, type_o, subtype_o, word_o} = 49'h0;
  // released fields are inverted so stale values never look valid
  task automatic send(logic [7:0] t, s, logic [31:0] w);
    @(negedge clk_i);
    {valid_o, type_o, subtype_o, word_o} = {1'b1, t, s, w};
    @(negedge clk_i);
    {valid_o, type_o, subtype_o, word_o} = {1'b0, ~t, ~s, ~w};
  endtask
endmodule

// >>> shader_texture_param_bank_tb_top.sv
/*
  Self-checking bench of the parameter bank.
  Assumes the bank, its checker and the word source model.
*/
`timescale 1ns/1ps
module shader_texture_param_bank_tb_top;
  logic clk_i = 1'b0, rst_n_i = 1'b0, alu_query_i = 1'b0, param_valid_i;
  logic dst_first_use_i = 1'b0, dst_partial_i = 1'b0, dst_reg_valid_i = 1'b0;
  logic [6:0] alu_index_i = 7'h00;
  logic [3:0] dst_reg_i = 4'h0;
  shader_tex_pkg::stage_t tex_stage_i = 4'h0;
  shader_tex_pkg::face_t tex_face_i = 3'h0;
  logic switch_valid_o, switch_known_o, switch_tex_o, alu_stall_o, face_known_o;
  logic [7:0] param_type_i, param_subtype_i;
  logic [31:0] param_word_i, face_base_o;
  logic [13:0] inspect_flag_o;
  int n_mismatch = 0, compares = 0;
  always #4 clk_i = ~clk_i;
  shader_texture_param_bank i_shader_texture_param_bank (.clk_i, .rst_n_i, .param_valid_i,
    .param_type_i, .param_subtype_i, .param_word_i, .alu_query_i, .alu_index_i,
    .switch_valid_o, .switch_known_o, .switch_tex_o, .dst_reg_i, .dst_first_use_i,
    .dst_partial_i, .dst_reg_valid_i, .alu_stall_o, .tex_stage_i, .tex_face_i,
    .face_base_o, .face_known_o, .inspect_flag_o);
  param_word_source i_param_word_source (.clk_i, .valid_o(param_valid_i),
    .type_o(param_type_i), .subtype_o(param_subtype_i), .word_o(param_word_i));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] t, s, logic [31:0] w);
    i_param_word_source.send(t, s, w);
  endtask
  task automatic face(logic [3:0] s, logic [2:0] f, logic [31:0] e);
    @(negedge clk_i);
    {tex_stage_i, tex_face_i} = {s, f};
    @(negedge clk_i);
    chk("face_base_o", e, face_base_o);
    chk("face_known_o", 32'(f <= 3'h4), 32'(face_known_o));
  endtask
  task automatic ask(logic [6:0] i, logic t);
    @(negedge clk_i);
    {alu_query_i, alu_index_i} = {1'b1, i};
    @(negedge clk_i);
    alu_query_i = 1'b0;
    chk("switch_o", 32'({i >= 7'h5F, t, 1'b1}),
      32'({switch_known_o, switch_tex_o, switch_valid_o}));
  endtask
  task automatic stall(logic [3:0] r, logic [2:0] c, logic e);
    @(negedge clk_i);
    {dst_reg_i, dst_first_use_i, dst_partial_i, dst_reg_valid_i} = {r, c};
    #1 chk("alu_stall_o", 32'(e), 32'(alu_stall_o));
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int f = 0; f < 5; f++) begin
      wr(8'h02, 8'h03, {8'(f), 24'hA1B2C0 + 24'(f)});
      wr(8'h02, 8'h0F, {8'(f), 24'h3C4D50 + 24'(f)});
    end
    wr(8'h02, 8'h10, 32'h00FFFFFF);
    wr(8'h02, 8'h03, 32'h05FFFFFF);
    for (int f = 0; f < 6; f++) begin
      face(4'h3, 3'(f), f < 5 ? {24'hA1B2C0 + 24'(f), 8'h00} : 32'h0);
      face(4'hF, 3'(f), f < 5 ? {24'h3C4D50 + 24'(f), 8'h00} : 32'h0);
    end
    face(4'h0, 3'h0, 32'h0);
    wr(8'h02, 8'h03, 32'h02000000);
    face(4'h3, 3'h2, 32'h0);
    wr(8'h01, 8'h00, 32'h99800001);
    wr(8'h01, 8'h00, 32'h9A000181);
    ask(7'h5F, 1'b1);
    ask(7'h60, 1'b0);
    ask(7'h76, 1'b1);
    ask(7'h78, 1'b1);
    ask(7'h79, 1'b0);
    ask(7'h7F, 1'b1);
    ask(7'h0A, 1'b0);
    stall(4'h0, 3'b110, 1'b1);
    stall(4'h0, 3'b111, 1'b0);
    stall(4'h0, 3'b010, 1'b0);
    stall(4'h1, 3'b110, 1'b0);
    wr(8'h01, 8'h00, 32'h9A800000);
    stall(4'hF, 3'b110, 1'b1);
    stall(4'h0, 3'b110, 1'b0);
    wr(8'h01, 8'h00, 32'hAAFFFABC);
    chk("inspect_flag_o", 32'h3ABC, 32'(inspect_flag_o));
    tally_and_finish;
  end
  initial begin
    #50000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
